//--- pcp_regs.sv
/*
 APB register bank for the configuration header tail and the power
 management capability block, with event status and interrupt.
 Assumes pin inputs are asynchronous to pclk and EEPROM load data is
 produced on pclk; one wait state on every APB transfer.
*/
`timescale 1ns/1ps
module pcp_regs
    import pcp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic aux_supply_detect,
    input wire logic pm_event_in,
    input wire logic eeprom_load,
    input wire logic [7:0] eeprom_min_grant,
    input wire logic [7:0] eeprom_max_latency,
    input wire logic [31:0] eeprom_scale_table,
    output logic pm_event_out,
    output logic irq
);

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_flt;
    logic evt_flt_d_r;
    logic aux_flt_d_r;
    logic evt_rise;
    logic aux_chg;

    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic pslverr_nxt;
    logic xfer_done;
    logic wr_done;
    logic rd_done;

    logic [7:0] int_line_r;
    logic [7:0] min_grant_r;
    logic [7:0] max_latency_r;
    logic [31:0] scale_table_r;
    logic pm_event_status_flag_r;
    logic [1:0] power_reading_scale_r;
    logic [3:0] power_reading_select_r;
    logic pm_event_enable_r;
    logic [1:0] power_state_field_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_stat_nxt;
    logic [IRQ_W-1:0] irq_mask_r;
    logic pm_event_out_r;
    logic irq_r;

    logic [15:0] cap_word;
    logic addr_mapped;
    logic [15:0] csr_word;
    logic csr_wr_lo;
    logic csr_wr_hi;

    assign pin_raw = {pm_event_in, aux_supply_detect};

    // Three-stage synchroniser; the level moves only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < PIN_W; g++) begin : g_sync
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic flt_r;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    flt_r <= 1'b0;
                end else begin
                    s1_r <= pin_raw[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        flt_r <= s3_r;
                    end
                end
            end
            assign pin_flt[g] = flt_r;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_flt_d_r <= 1'b0;
            aux_flt_d_r <= 1'b0;
        end else begin
            evt_flt_d_r <= pin_flt[PIN_EVT];
            aux_flt_d_r <= pin_flt[PIN_AUX];
        end
    end

    assign evt_rise = pin_flt[PIN_EVT] & ~evt_flt_d_r;
    assign aux_chg = pin_flt[PIN_AUX] ^ aux_flt_d_r;

    assign xfer_done = psel & penable & pready_r;
    assign wr_done = xfer_done & pwrite;
    assign rd_done = xfer_done & ~pwrite;
    assign csr_wr_lo = wr_done && (paddr == OFS_CTRL_STAT) && pstrb[0];
    assign csr_wr_hi = wr_done && (paddr == OFS_CTRL_STAT) && pstrb[1];
    // Own decode, so the error check does not lean on the read mux
    assign addr_mapped = (paddr == OFS_HDR) || (paddr == OFS_CAPPTR) || (paddr == OFS_PMCAP)
        || (paddr == OFS_CTRL_STAT) || (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);

    // Fixed capability fields; only bit 15 is live
    assign cap_word = {pin_flt[PIN_AUX], 4'h0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0,
                       PM_VERSION};

    assign csr_word = {pm_event_status_flag_r, power_reading_scale_r, power_reading_select_r,
                       pm_event_enable_r, 6'h00, power_state_field_r};

    // Read mux; the word is captured in the wait cycle so prdata is a flop
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        unique case (paddr)
            OFS_HDR: begin
                prdata_nxt = {max_latency_r, min_grant_r, INT_PIN_VAL, int_line_r};
            end
            OFS_CAPPTR: begin
                prdata_nxt = {BYTE_ZERO, BYTE_ZERO, BYTE_ZERO, CAP_LIST_PTR};
            end
            OFS_PMCAP: begin
                prdata_nxt = {cap_word, NEXT_PTR_VAL, CAP_ID_VAL};
            end
            OFS_CTRL_STAT: begin
                prdata_nxt = {16'h0000, csr_word};
            end
            OFS_IRQ_STAT: begin
                prdata_nxt = {29'h0000_0000, irq_stat_r};
            end
            OFS_IRQ_MASK: begin
                prdata_nxt = {29'h0000_0000, irq_mask_r};
            end
            default: begin
                pslverr_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel && penable && !pready_r) begin
            pready_r <= 1'b1;
            prdata_r <= pwrite ? 32'h0000_0000 : prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end else begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end

    // Routing byte: only lane 0 of the header word is writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_line_r <= 8'h00;
        end else if (wr_done && (paddr == OFS_HDR) && pstrb[0]) begin
            int_line_r <= pwdata[7:0];
        end
    end

    // Host writes never reach these; only the EEPROM loader does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_grant_r <= 8'h00;
            max_latency_r <= 8'h00;
            scale_table_r <= 32'h0000_0000;
        end else if (eeprom_load) begin
            min_grant_r <= eeprom_min_grant;
            max_latency_r <= eeprom_max_latency;
            scale_table_r <= eeprom_scale_table;
        end
    end

    // Scale is read-only and follows the select field through the loaded table
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_reading_scale_r <= 2'h0;
        end else begin
            power_reading_scale_r <= scale_table_r[{power_reading_select_r, 1'b0} +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_state_field_r <= 2'h0;
        end else if (csr_wr_lo) begin
            power_state_field_r <= pwdata[CSR_STATE_LO +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_reading_select_r <= 4'h0;
            pm_event_enable_r <= 1'b0;
        end else if (csr_wr_hi) begin
            power_reading_select_r <= pwdata[CSR_SEL_LO +: 4];
            pm_event_enable_r <= pwdata[CSR_EN_BIT];
        end
    end

    // A new event in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_event_status_flag_r <= 1'b0;
        end else if (evt_rise) begin
            pm_event_status_flag_r <= 1'b1;
        end else if (csr_wr_hi && pwdata[CSR_STAT_BIT]) begin
            pm_event_status_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_event_out_r <= 1'b0;
        end else begin
            pm_event_out_r <= pm_event_status_flag_r & pm_event_enable_r;
        end
    end

    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (rd_done && (paddr == OFS_IRQ_STAT)) begin
            irq_stat_nxt = '0;
        end
        if (evt_rise) begin
            irq_stat_nxt[IRQ_PM_EVENT] = 1'b1;
        end
        if (aux_chg) begin
            irq_stat_nxt[IRQ_AUX_CHG] = 1'b1;
        end
        if (csr_wr_lo) begin
            irq_stat_nxt[IRQ_STATE_WR] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= '0;
        end else if (wr_done && (paddr == OFS_IRQ_MASK) && pstrb[0]) begin
            irq_mask_r <= pwdata[IRQ_W-1:0];
        end
    end

    // One cycle behind the status bits so the pin stays a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pm_event_out = pm_event_out_r;
    assign irq = irq_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd(logic [7:0] a);
        rd_done && (paddr == a);
    endsequence

    sequence s_stat_clear;
        csr_wr_hi && pwdata[CSR_STAT_BIT] && !evt_rise;
    endsequence

    a_cap_ptr_fixed: assert property (s_rd(OFS_CAPPTR) |-> prdata[7:0] == CAP_LIST_PTR)
        else $error("capability pointer not 40h");
    a_int_line_wr: assert property (wr_done && paddr == OFS_HDR && pstrb[0]
        |=> int_line_r == $past(pwdata[7:0]))
        else $error("routing byte not stored");
    a_int_pin_one: assert property (s_rd(OFS_HDR) |-> prdata[15:8] == INT_PIN_VAL)
        else $error("interrupt pin not 1");
    a_grant_readonly: assert property (!eeprom_load
        |=> $stable(min_grant_r) && $stable(max_latency_r))
        else $error("grant or latency changed without load");
    a_cap_id_next: assert property (s_rd(OFS_PMCAP) |-> prdata[15:0] == 16'h0001)
        else $error("capability_identifier or next pointer wrong");
    a_aux_bit_level: assert property (s_rd(OFS_PMCAP)
        |-> prdata[31] == $past(pin_flt[PIN_AUX]))
        else $error("aux detect bit mismatch");
    a_cap_fixed: assert property (s_rd(OFS_PMCAP)
        |-> prdata[30:16] == 15'h0003)
        else $error("fixed capability fields wrong");
    a_csr_rsvd_zero: assert property (s_rd(OFS_CTRL_STAT)
        |-> prdata[7:2] == 6'h00 && prdata[31:16] == 16'h0000)
        else $error("reserved control bits not zero");
    a_stat_w1c: assert property (s_stat_clear |=> !pm_event_status_flag_r)
        else $error("event status not cleared");
    a_stat_w0_keep: assert property (csr_wr_hi && !pwdata[CSR_STAT_BIT]
        && pm_event_status_flag_r |=> pm_event_status_flag_r)
        else $error("write of 0 cleared event status");
    a_pme_drive: assert property (pm_event_status_flag_r && pm_event_enable_r
        |=> pm_event_out)
        else $error("event output not asserted");
    a_pme_quiet: assert property (!pm_event_enable_r |=> !pm_event_out)
        else $error("event output asserted while disabled");
    a_pme_off: assert property (!pm_event_status_flag_r |=> !pm_event_out)
        else $error("event output asserted without status");
    a_evt_sets_flag: assert property (evt_rise |=> pm_event_status_flag_r)
        else $error("event did not set status");

    // Every transfer gets exactly one wait state and a single-cycle answer
    a_pready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after wait state");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_setup_no_ready: assert property (!(psel && penable) |=> !pready)
        else $error("ready outside access phase");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer cycle");
    a_err_unmapped: assert property (xfer_done && !addr_mapped |-> pslverr)
        else $error("unmapped access without error");
    a_err_mapped: assert property (xfer_done && addr_mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    a_state_wr: assert property (csr_wr_lo
        |=> power_state_field_r == $past(pwdata[CSR_STATE_LO +: 2]))
        else $error("power state not stored");
    a_sel_en_wr: assert property (csr_wr_hi
        |=> power_reading_select_r == $past(pwdata[CSR_SEL_LO +: 4])
        && pm_event_enable_r == $past(pwdata[CSR_EN_BIT]))
        else $error("select or enable not stored");
    a_scale_follows: assert property (1'b1
        |=> power_reading_scale_r == $past(scale_table_r[{power_reading_select_r, 1'b0} +: 2]))
        else $error("scale does not follow select");
    a_grant_load: assert property (eeprom_load
        |=> min_grant_r == $past(eeprom_min_grant)
        && max_latency_r == $past(eeprom_max_latency))
        else $error("grant or latency not loaded");

    // The interrupt pin trails the masked status by one cycle
    a_irq_on: assert property ((|(irq_stat_r & irq_mask_r)) |=> irq)
        else $error("interrupt not raised");
    a_irq_off: assert property (!(|(irq_stat_r & irq_mask_r)) |=> !irq)
        else $error("interrupt raised with no pending bit");
    a_irq_rd_clear: assert property (rd_done && paddr == OFS_IRQ_STAT && !evt_rise && !aux_chg
        |=> irq_stat_r == '0)
        else $error("status read did not clear");
    a_irq_evt_set: assert property (evt_rise |=> irq_stat_r[IRQ_PM_EVENT])
        else $error("event status bit not set");
    a_irq_aux_set: assert property (aux_chg |=> irq_stat_r[IRQ_AUX_CHG])
        else $error("aux change bit not set");
    a_mask_wr: assert property (wr_done && paddr == OFS_IRQ_MASK && pstrb[0]
        |=> irq_mask_r == $past(pwdata[IRQ_W-1:0]))
        else $error("mask not stored");

endmodule

//--- pcp_pkg.sv
/*
 Constants for the configuration header tail and power management
 capability block: register offsets, field positions, reset values.
 Assumes an APB slave with 32-bit data and byte strobes in front.
*/
package pcp_pkg;

    localparam logic [7:0] OFS_HDR = 8'h00;
    localparam logic [7:0] OFS_CAPPTR = 8'h04;
    localparam logic [7:0] OFS_PMCAP = 8'h08;
    localparam logic [7:0] OFS_CTRL_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    localparam logic [7:0] CAP_LIST_PTR = 8'h40;
    localparam logic [7:0] INT_PIN_VAL = 8'h01;
    localparam logic [7:0] CAP_ID_VAL = 8'h01;
    localparam logic [7:0] NEXT_PTR_VAL = 8'h00;
    localparam logic [2:0] PM_VERSION = 3'h3;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    localparam int CSR_STAT_BIT = 15;
    localparam int CSR_SCALE_LO = 13;
    localparam int CSR_SEL_LO = 9;
    localparam int CSR_EN_BIT = 8;
    localparam int CSR_STATE_LO = 0;

    localparam int IRQ_W = 3;
    localparam int IRQ_PM_EVENT = 0;
    localparam int IRQ_AUX_CHG = 1;
    localparam int IRQ_STATE_WR = 2;

    localparam int PIN_W = 2;
    localparam int PIN_AUX = 0;
    localparam int PIN_EVT = 1;

endpackage

//--- pcp_host_model.sv
/*
 Host side model: an APB master with one transfer task.
 Assumes a single pclk domain and a slave that answers with pready.
*/
`timescale 1ns/1ps
module pcp_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // Waits on pready as long as it takes; only the bench watchdog ends a hung wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Stale write data would hide a slave that samples too late
        pwdata <= ~d;
    endtask
endmodule

//--- pci_config_header_pm_capability_test.sv
/*
 Self-checking bench for the register bank: reset values, read-only
 fields, pin inputs, control/status word, event output and interrupt.
 Assumes the host model drives APB and the bench drives the pins.
*/
`timescale 1ns/1ps
module pci_config_header_pm_capability_test
    import pcp_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, pm_event_out, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic aux_supply_detect = 1'b0;
    logic pm_event_in = 1'b0;
    logic eeprom_load = 1'b0;
    logic [7:0] eeprom_min_grant = 8'h5A;
    logic [7:0] eeprom_max_latency = 8'hA5;
    logic [31:0] eeprom_scale_table = 32'h0000_00E4;
    int errors = 0;
    int tests_run = 0;

    always #10 pclk = ~pclk;

    pcp_regs i_pcp_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .aux_supply_detect(aux_supply_detect),
        .pm_event_in(pm_event_in), .eeprom_load(eeprom_load),
        .eeprom_min_grant(eeprom_min_grant), .eeprom_max_latency(eeprom_max_latency),
        .eeprom_scale_table(eeprom_scale_table), .pm_event_out(pm_event_out), .irq(irq));

    pcp_host_model i_pcp_host_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        i_pcp_host_model.xfer(1'b1, a, d, 4'hF, r, e);
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        i_pcp_host_model.xfer(1'b0, a, 32'h0000_0000, 4'hF, r, e);
        chk(name, exp, r);
    endtask

    task automatic summarize();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        summarize();
    end

    initial begin
        logic [31:0] r;
        logic e;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd("hdr", OFS_HDR, 32'h0000_0100);
        rd("capptr", OFS_CAPPTR, 32'h0000_0040);
        rd("pmcap", OFS_PMCAP, 32'h0003_0001);
        rd("csr", OFS_CTRL_STAT, 32'h0000_0000);
        wr(OFS_HDR, 32'hFFFF_FFFF);
        rd("hdr_wr", OFS_HDR, 32'h0000_01FF);
        wr(OFS_CAPPTR, 32'hFFFF_FFFF);
        rd("capptr_wr", OFS_CAPPTR, 32'h0000_0040);
        wr(OFS_PMCAP, 32'hFFFF_FFFF);
        rd("pmcap_wr", OFS_PMCAP, 32'h0003_0001);
        @(posedge pclk);
        aux_supply_detect <= 1'b1;
        repeat (8) @(posedge pclk);
        rd("pmcap_aux", OFS_PMCAP, 32'h8003_0001);
        chk("irq_masked", 32'h0, {31'h0, irq});
        eeprom_load <= 1'b1;
        @(posedge pclk);
        eeprom_load <= 1'b0;
        rd("hdr_eeprom", OFS_HDR, 32'hA55A_01FF);
        wr(OFS_CTRL_STAT, 32'h0000_1F03);
        rd("csr_sel15", OFS_CTRL_STAT, 32'h0000_1F03);
        wr(OFS_CTRL_STAT, 32'h0000_0703);
        rd("csr_sel3", OFS_CTRL_STAT, 32'h0000_6703);
        wr(OFS_CTRL_STAT, 32'h0000_07FF);
        rd("csr_rsvd", OFS_CTRL_STAT, 32'h0000_6703);
        @(posedge pclk);
        pm_event_in <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("event_out", 32'h1, {31'h0, pm_event_out});
        rd("csr_evt", OFS_CTRL_STAT, 32'h0000_E703);
        // Lane 1 not strobed: neither the clear bit nor the select may land
        i_pcp_host_model.xfer(1'b1, OFS_CTRL_STAT, 32'h0000_9E00, 4'h1, r, e);
        chk("lane_err", 32'h0, {31'h0, e});
        rd("csr_lane0", OFS_CTRL_STAT, 32'h0000_E700);
        wr(OFS_IRQ_MASK, 32'h0000_0007);
        repeat (2) @(posedge pclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        rd("irq_stat", OFS_IRQ_STAT, 32'h0000_0007);
        repeat (2) @(posedge pclk);
        chk("irq_off", 32'h0, {31'h0, irq});
        rd("irq_clr", OFS_IRQ_STAT, 32'h0000_0000);
        wr(OFS_CTRL_STAT, 32'h0000_0703);
        rd("csr_w0", OFS_CTRL_STAT, 32'h0000_E703);
        wr(OFS_CTRL_STAT, 32'h0000_8703);
        rd("csr_w1c", OFS_CTRL_STAT, 32'h0000_6703);
        repeat (2) @(posedge pclk);
        chk("event_clr", 32'h0, {31'h0, pm_event_out});
        i_pcp_host_model.xfer(1'b0, 8'h20, 32'h0000_0000, 4'hF, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
        summarize();
    end
endmodule
